// ===== pkg/eac_pkg.sv
// Constants, types and register map of the nonvolatile access controller
package eac_pkg;

    // I/O space offsets
    localparam logic [5:0] OFF_CTRL   = 6'h1c;
    localparam logic [5:0] OFF_DATA   = 6'h1d;
    localparam logic [5:0] OFF_ADDR_L = 6'h1e;
    localparam logic [5:0] OFF_ADDR_H = 6'h1f;

    // Array geometry
    localparam int unsigned NVM_BYTES = 512;
    localparam int unsigned ADDR_W    = 9;

    // Control register and high address register fields
    localparam int unsigned BIT_RD_STROBE = 0;
    localparam int unsigned BIT_WR_STROBE = 1;
    localparam int unsigned BIT_MWE       = 2;
    localparam int unsigned BIT_RIE       = 3;
    localparam int unsigned BIT_ADDR_HI   = 0;

    // Reset values
    localparam logic [8:0] ADDR_RST = 9'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [7:0] ZERO8    = 8'h00;

    // Timing counts
    localparam logic [2:0]  MWE_CYC     = 3'h4;
    localparam logic [2:0]  RD_STALL    = 3'h4;
    localparam logic [2:0]  WR_STALL    = 3'h2;
    localparam logic [2:0]  CNT3_ZERO   = 3'h0;
    localparam logic [2:0]  CNT3_ONE    = 3'h1;
    localparam int unsigned WR_RC_CYC   = 2048;
    localparam logic [10:0] WR_CNT_LAST = 11'(WR_RC_CYC - 1);
    localparam logic [10:0] WR_CNT_ZERO = 11'h000;

    // CPU I/O access
    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [5:0] addr;
        logic [7:0] wdata;
    } eac_io_s;

    // Whole block state
    typedef struct packed {
        logic [8:0]  addr;
        logic [7:0]  data;
        logic        rie;
        logic        mwe;
        logic [2:0]  mwe_cnt;
        logic        busy;
        logic [10:0] wr_cnt;
        logic [8:0]  wr_addr;
        logic [7:0]  wr_data;
        logic        rd_pend;
        logic [2:0]  stall_cnt;
        logic [7:0]  rdata;
        logic        rc_s1;
        logic        rc_s2;
        logic        rc_s3;
    } eac_state_s;

endpackage

// ===== design/eac_ctrl.sv
// Data EEPROM access controller: registers, unlock, write timing, reads, stall, ready interrupt
//
// Notes on behaviour
// - Nine-bit address selects bytes 0 to 511
// - Unused address and control bits read zero
// - Data register feeds writes, receives read bytes
// - Ready interrupt held while write strobe zero
// - Master write enable self-clears after four cycles
// - Write strobe without enable starts nothing
// - Write strobe with enable starts programming
// - Write strobe stays set until programming ends
// - Write lasts 2048 calibrated oscillator cycles
// - Read strobe fetches byte, clears itself
// - During write, ignore reads and address changes
// - Read stalls processor four cycles
// - Write stalls processor two cycles
// - Reset does not abort a running write
`timescale 1ns/1ps
`default_nettype none

module eac_ctrl
    import eac_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic       nrst_in,
    input  wire eac_io_s    io_in,
    input  wire logic       gie_in,
    input  wire logic       rc_clk_in,
    output logic      [7:0] io_rdata_out,
    output logic            stall_out,
    output logic            irq_out
);

    eac_state_s st_r;
    eac_state_s st_nxt;
    logic [7:0] mem [NVM_BYTES];
    logic       mwe_set;
    logic       wr_start;
    logic       rd_start;
    logic       prog_done;
    logic       rc_edge;
    logic [7:0] ctrl_val;

    function automatic logic hit(input eac_io_s io, input logic [5:0] off);
        return io.wr && (io.addr == off);
    endfunction

    // Control register image, upper bits zero
    always_comb begin
        ctrl_val = ZERO8;
        ctrl_val[BIT_RIE]       = st_r.rie;
        ctrl_val[BIT_MWE]       = st_r.mwe;
        ctrl_val[BIT_WR_STROBE] = st_r.busy;
        ctrl_val[BIT_RD_STROBE] = st_r.rd_pend;
    end

    assign rc_edge   = st_r.rc_s2 && !st_r.rc_s3;
    assign prog_done = st_r.busy && rc_edge && (st_r.wr_cnt == WR_CNT_LAST);
    assign mwe_set   = hit(io_in, OFF_CTRL) && io_in.wdata[BIT_MWE];
    assign wr_start  = hit(io_in, OFF_CTRL) && io_in.wdata[BIT_WR_STROBE]
                       && st_r.mwe && !st_r.busy;
    assign rd_start  = hit(io_in, OFF_CTRL) && io_in.wdata[BIT_RD_STROBE]
                       && !st_r.busy && !wr_start;

    always_comb begin
        st_nxt = st_r;

        // Oscillator synchroniser
        st_nxt.rc_s1 = rc_clk_in;
        st_nxt.rc_s2 = st_r.rc_s1;
        st_nxt.rc_s3 = st_r.rc_s2;

        // Address registers, frozen while programming
        if (hit(io_in, OFF_ADDR_L) && !st_r.busy) begin
            st_nxt.addr[7:0] = io_in.wdata;
        end
        if (hit(io_in, OFF_ADDR_H) && !st_r.busy) begin
            st_nxt.addr[8] = io_in.wdata[BIT_ADDR_HI];
        end

        // Data register
        if (hit(io_in, OFF_DATA)) begin
            st_nxt.data = io_in.wdata;
        end

        // Control register software writes
        if (hit(io_in, OFF_CTRL)) begin
            st_nxt.rie = io_in.wdata[BIT_RIE];
            if (!io_in.wdata[BIT_MWE]) begin
                st_nxt.mwe     = 1'b0;
                st_nxt.mwe_cnt = CNT3_ZERO;
            end
        end

        // Master write enable timeout
        if (mwe_set) begin
            st_nxt.mwe     = 1'b1;
            st_nxt.mwe_cnt = MWE_CYC;
        end else if (st_r.mwe) begin
            if (st_r.mwe_cnt == CNT3_ONE) begin
                st_nxt.mwe     = 1'b0;
                st_nxt.mwe_cnt = CNT3_ZERO;
            end else begin
                st_nxt.mwe_cnt = st_r.mwe_cnt - CNT3_ONE;
            end
        end

        // Stall countdown
        if (st_r.stall_cnt != CNT3_ZERO) begin
            st_nxt.stall_cnt = st_r.stall_cnt - CNT3_ONE;
        end

        // Programming start and timing
        if (wr_start) begin
            st_nxt.busy      = 1'b1;
            st_nxt.wr_cnt    = WR_CNT_ZERO;
            st_nxt.wr_addr   = st_r.addr;
            st_nxt.wr_data   = hit(io_in, OFF_DATA) ? io_in.wdata : st_r.data;
            st_nxt.stall_cnt = WR_STALL;
        end else if (prog_done) begin
            st_nxt.busy   = 1'b0;
            st_nxt.wr_cnt = WR_CNT_ZERO;
        end else if (st_r.busy && rc_edge) begin
            st_nxt.wr_cnt = st_r.wr_cnt + 11'h001;
        end

        // Single-instruction read
        st_nxt.rd_pend = 1'b0;
        if (rd_start) begin
            st_nxt.rd_pend   = 1'b1;
            st_nxt.stall_cnt = RD_STALL;
        end
        if (st_r.rd_pend) begin
            st_nxt.data = mem[st_r.addr];
        end

        // Registered read data
        st_nxt.rdata = ZERO8;
        if (io_in.rd) begin
            unique case (io_in.addr)
                OFF_CTRL:   st_nxt.rdata = ctrl_val;
                OFF_DATA:   st_nxt.rdata = st_r.data;
                OFF_ADDR_L: st_nxt.rdata = st_r.addr[7:0];
                OFF_ADDR_H: st_nxt.rdata = {7'h00, st_r.addr[8]};
                default:    st_nxt.rdata = ZERO8;
            endcase
        end

        // Reset leaves a running write alone
        if (!nrst_in) begin
            st_nxt.addr      = ADDR_RST;
            st_nxt.data      = DATA_RST;
            st_nxt.rie       = 1'b0;
            st_nxt.mwe       = 1'b0;
            st_nxt.mwe_cnt   = CNT3_ZERO;
            st_nxt.rd_pend   = 1'b0;
            st_nxt.stall_cnt = CNT3_ZERO;
            st_nxt.rdata     = ZERO8;
            // An unknown power-up flag falls to idle here
            if (st_r.busy && !prog_done) begin
                st_nxt.busy = 1'b1;
            end else begin
                st_nxt.busy = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_in) begin
        st_r <= st_nxt;
    end

    // Programming of the array at the end of the write time
    always_ff @(posedge clk_in) begin
        if (prog_done) begin
            mem[st_r.wr_addr] <= st_r.wr_data;
        end
    end

    assign io_rdata_out = st_r.rdata;
    assign stall_out    = (st_r.stall_cnt != CNT3_ZERO);
    assign irq_out      = st_r.rie && gie_in && !st_r.busy;

    // Checks

    sequence s_ctrl_wr;
        hit(io_in, OFF_CTRL);
    endsequence

    sequence s_two_stall;
        stall_out [*2] ##1 !stall_out;
    endsequence

    sequence s_unlock_lapse;
        mwe_set ##1 (!mwe_set) [*4];
    endsequence

    property p_mwe_timeout;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.mwe && st_r.mwe_cnt == CNT3_ONE && !mwe_set) |=> !st_r.mwe;
    endproperty
    a_mwe_timeout: assert property (p_mwe_timeout) else $error("enable did not time out");

    property p_mwe_load;
        @(posedge clk_in) disable iff (!nrst_in)
        mwe_set |=> (st_r.mwe && st_r.mwe_cnt == MWE_CYC);
    endproperty
    a_mwe_load: assert property (p_mwe_load) else $error("enable not loaded");

    property p_no_unlock;
        @(posedge clk_in) disable iff (!nrst_in)
        (s_ctrl_wr ##0 (io_in.wdata[BIT_WR_STROBE] && !st_r.mwe && !st_r.busy))
        |=> !st_r.busy;
    endproperty
    a_no_unlock: assert property (p_no_unlock) else $error("write started while locked");

    property p_start;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_start |=> (st_r.busy && st_r.wr_addr == $past(st_r.addr) && !irq_out);
    endproperty
    a_start: assert property (p_start) else $error("write start wrong");

    property p_irq_level;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.rie && gie_in) |-> (irq_out == !ctrl_val[BIT_WR_STROBE]);
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("ready interrupt wrong");

    property p_rd_blocked;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.busy && !prog_done) |=> (st_r.addr == $past(st_r.addr) && !st_r.rd_pend);
    endproperty
    a_rd_blocked: assert property (p_rd_blocked) else $error("access during write");

    property p_rd_stall;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_start |=> stall_out [*4] ##1 !stall_out;
    endproperty
    a_rd_stall: assert property (p_rd_stall) else $error("read stall length wrong");

    property p_wr_stall;
        @(posedge clk_in) disable iff (!nrst_in)
        wr_start |=> s_two_stall;
    endproperty
    a_wr_stall: assert property (p_wr_stall) else $error("write stall length wrong");

    property p_rd_done;
        @(posedge clk_in) disable iff (!nrst_in)
        rd_start |=> st_r.rd_pend ##1 (!st_r.rd_pend && st_r.data == mem[$past(st_r.addr)]);
    endproperty
    a_rd_done: assert property (p_rd_done) else $error("read did not complete");

    property p_busy_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.busy && !rc_edge) |=> st_r.busy;
    endproperty
    a_busy_hold: assert property (p_busy_hold) else $error("write ended early");

    property p_keep_write;
        @(posedge clk_in)
        (!nrst_in && st_r.busy && !prog_done) |=> st_r.busy;
    endproperty
    a_keep_write: assert property (p_keep_write) else $error("reset aborted a write");

    property p_mwe_lapse;
        @(posedge clk_in) disable iff (!nrst_in)
        s_unlock_lapse |=> !st_r.mwe;
    endproperty
    a_mwe_lapse: assert property (p_mwe_lapse) else $error("enable outlived its window");

    property p_rd_ignored;
        @(posedge clk_in) disable iff (!nrst_in)
        (nrst_in && hit(io_in, OFF_CTRL) && io_in.wdata[BIT_RD_STROBE] && st_r.busy)
        |=> (!st_r.rd_pend && $stable(st_r.data));
    endproperty
    a_rd_ignored: assert property (p_rd_ignored) else $error("read taken during write");

    property p_rd_pend_idle;
        @(posedge clk_in) disable iff (!nrst_in)
        st_r.rd_pend |-> !st_r.busy;
    endproperty
    a_rd_pend_idle: assert property (p_rd_pend_idle) else $error("read beside write");

    property p_capture_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.busy && !prog_done) |=> ($stable(st_r.wr_addr) && $stable(st_r.wr_data));
    endproperty
    a_capture_hold: assert property (p_capture_hold) else $error("captured word moved");

    property p_prog_write;
        @(posedge clk_in) disable iff (!nrst_in)
        prog_done |=> (mem[$past(st_r.wr_addr)] == $past(st_r.wr_data));
    endproperty
    a_prog_write: assert property (p_prog_write) else $error("array not programmed");

    property p_done_clears;
        @(posedge clk_in) disable iff (!nrst_in)
        prog_done |=> !st_r.busy;
    endproperty
    a_done_clears: assert property (p_done_clears) else $error("write strobe stuck");

    property p_busy_rd;
        @(posedge clk_in) disable iff (!nrst_in)
        (nrst_in && io_in.rd && io_in.addr == OFF_CTRL && st_r.busy)
        |=> io_rdata_out[BIT_WR_STROBE];
    endproperty
    a_busy_rd: assert property (p_busy_rd) else $error("busy not visible");

    property p_wr_cnt_step;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.busy && rc_edge && !prog_done) |=> (st_r.wr_cnt == $past(st_r.wr_cnt) + 11'h001);
    endproperty
    a_wr_cnt_step: assert property (p_wr_cnt_step) else $error("write count skipped");

    property p_wr_cnt_hold;
        @(posedge clk_in) disable iff (!nrst_in)
        (st_r.busy && !rc_edge) |=> $stable(st_r.wr_cnt);
    endproperty
    a_wr_cnt_hold: assert property (p_wr_cnt_hold) else $error("write count drifted");

    property p_irq_busy;
        @(posedge clk_in) disable iff (!nrst_in)
        st_r.busy |-> !irq_out;
    endproperty
    a_irq_busy: assert property (p_irq_busy) else $error("ready raised while busy");

    property p_addr_l_write;
        @(posedge clk_in) disable iff (!nrst_in)
        (nrst_in && hit(io_in, OFF_ADDR_L) && !st_r.busy) |=> (st_r.addr[7:0] == $past(io_in.wdata));
    endproperty
    a_addr_l_write: assert property (p_addr_l_write) else $error("low address not taken");

    property p_addr_h_write;
        @(posedge clk_in) disable iff (!nrst_in)
        (nrst_in && hit(io_in, OFF_ADDR_H) && !st_r.busy)
        |=> (st_r.addr[ADDR_W-1] == $past(io_in.wdata[BIT_ADDR_HI]));
    endproperty
    a_addr_h_write: assert property (p_addr_h_write) else $error("high address not taken");

    property p_ctrl_rsvd;
        @(posedge clk_in) disable iff (!nrst_in)
        (io_in.rd && io_in.addr == OFF_CTRL) |=> ((io_rdata_out >> (BIT_RIE + 1)) == ZERO8);
    endproperty
    a_ctrl_rsvd: assert property (p_ctrl_rsvd) else $error("control spare bits set");

    property p_addr_h_rsvd;
        @(posedge clk_in) disable iff (!nrst_in)
        (io_in.rd && io_in.addr == OFF_ADDR_H) |=> ((io_rdata_out >> (BIT_ADDR_HI + 1)) == ZERO8);
    endproperty
    a_addr_h_rsvd: assert property (p_addr_h_rsvd) else $error("address spare bits set");

endmodule // eac_ctrl

`default_nettype wire

// ===== testbench/eac_cpu_model.sv
// CPU core model: I/O accesses, interrupt flag and calibrated oscillator
`timescale 1ns/1ps
`default_nettype none

module eac_cpu_model
    import eac_pkg::*;
#(
    parameter int RC_HALF_NS = 130
) (
    input  wire logic       clk_in,
    input  wire logic       stall_in,
    input  wire logic [7:0] rdata_in,
    output var  eac_io_s    io_out,
    output var  logic       gie_out,
    output var  logic       rc_clk_out
);
    initial begin
        io_out = '0;
        gie_out = 1'b1;
        rc_clk_out = 1'b0;
        #7;
        forever #(RC_HALF_NS) rc_clk_out = ~rc_clk_out;
    end

    // One access, never while halted; idle lines scrambled
    task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                       output logic [7:0] q);
        while (stall_in !== 1'b0) begin
            @(posedge clk_in);
            #1;
        end
        @(posedge clk_in);
        io_out <= '{w, ~w, a, d};
        @(posedge clk_in);
        io_out <= '{1'b0, 1'b0, ~a, ~d};
        #1;
        q = rdata_in;
    endtask

    task automatic wait_ready(output logic [7:0] q);
        q = 8'h02;
        for (int i = 0; i < 10000 && q[BIT_WR_STROBE] !== 1'b0; i++) begin
            acc(1'b0, OFF_CTRL, ZERO8, q);
        end
    endtask

    // Unlocked write with interrupts masked; gap stretches the unlock
    task automatic write_byte(input logic [8:0] a, input logic [7:0] d, input logic ie,
                              input int gap);
        logic [7:0] q;
        wait_ready(q);
        gie_out <= 1'b0;
        acc(1'b1, OFF_ADDR_L, a[7:0], q);
        acc(1'b1, OFF_ADDR_H, {7'h00, a[8]}, q);
        acc(1'b1, OFF_DATA, d, q);
        acc(1'b1, OFF_CTRL, {4'h0, ie, 3'h4}, q);
        repeat (gap) @(posedge clk_in);
        acc(1'b1, OFF_CTRL, {4'h0, ie, 3'h2}, q);
        gie_out <= 1'b1;
    endtask
endmodule // eac_cpu_model

`default_nettype wire

// ===== testbench/tb_top.sv
// Self-checking bench for the nonvolatile access controller
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import eac_pkg::*;
    localparam int RC_HALF = 130;
    localparam int WR_CYC  = WR_RC_CYC * RC_HALF * 2 / 40;
    logic        clk_in;
    logic        nrst_in;
    eac_io_s     io;
    logic        gie;
    logic        rc;
    logic [7:0]  rdata;
    logic        stall;
    logic        irq;
    int          bad_count = 0;
    int          compares = 0;
    int          cyc = 0;
    int          n;
    int          t0;
    logic [31:0] seed = 32'h00004b8d;
    logic [8:0]  a;
    logic [7:0]  d;
    logic [7:0]  q;

    eac_ctrl eac_ctrl_inst (.clk_in(clk_in), .nrst_in(nrst_in), .io_in(io), .gie_in(gie),
        .rc_clk_in(rc), .io_rdata_out(rdata), .stall_out(stall), .irq_out(irq));
    eac_cpu_model #(.RC_HALF_NS(RC_HALF)) eac_cpu_model_inst (.clk_in(clk_in),
        .stall_in(stall), .rdata_in(rdata), .io_out(io), .gie_out(gie), .rc_clk_out(rc));

    initial begin
        clk_in = 1'b0;
        forever #20 clk_in = ~clk_in;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            bad_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic ac(input logic w, input logic [5:0] ad, input logic [7:0] dd);
        eac_cpu_model_inst.acc(w, ad, dd, q);
    endtask

    task automatic stall_len(output int k);
        k = 0;
        while (stall === 1'b1 && k < 10) begin
            k++;
            @(posedge clk_in);
            #1;
        end
    endtask

    task automatic end_sim();
        $display("bad_count %0d compares %0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (cyc == 60000) begin
            bad_count++;
            end_sim();
        end
    end

    initial begin
        nrst_in = 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1;
        ac(1'b0, OFF_CTRL, ZERO8);
        chk("ctrl_reset", ZERO8, q);
        for (int i = 0; i < 6; i++) begin
            seed = xs(seed);
            a = (i == 0) ? 9'h1ff : seed[8:0];
            ac(1'b1, OFF_ADDR_L, a[7:0]);
            ac(1'b1, OFF_ADDR_H, {seed[15:9], a[8]});
            ac(1'b0, OFF_ADDR_L, ZERO8);
            chk("addr_low", a[7:0], q);
            ac(1'b0, OFF_ADDR_H, ZERO8);
            chk("addr_high", {7'h00, a[8]}, q);
        end
        ac(1'b1, OFF_CTRL, 8'hf2);
        ac(1'b0, OFF_CTRL, ZERO8);
        chk("ctrl_no_unlock", ZERO8, q);
        ac(1'b1, OFF_CTRL, 8'h08);
        chk("irq_idle", 8'h01, 8'(irq));
        d = seed[23:16];
        eac_cpu_model_inst.write_byte(9'h1ff, d, 1'b1, 0);
        t0 = cyc;
        stall_len(n);
        chk("write_stall", 8'(WR_STALL), 8'(n));
        chk("irq_busy", ZERO8, 8'(irq));
        ac(1'b1, OFF_ADDR_L, 8'h00);
        ac(1'b1, OFF_DATA, ~d);
        ac(1'b1, OFF_CTRL, 8'h09);
        ac(1'b0, OFF_CTRL, ZERO8);
        chk("ctrl_busy", 8'h0a, q);
        ac(1'b0, OFF_ADDR_L, ZERO8);
        chk("addr_locked", 8'hff, q);
        ac(1'b0, OFF_DATA, ZERO8);
        chk("data_hold", ~d, q);
        eac_cpu_model_inst.wait_ready(q);
        n = cyc - t0;
        chk("write_time", 8'h01, 8'(n > WR_CYC - 40 && n < WR_CYC + 40));
        chk("irq_ready", 8'h01, 8'(irq));
        ac(1'b1, OFF_CTRL, 8'h09);
        stall_len(n);
        chk("read_stall", 8'(RD_STALL), 8'(n));
        ac(1'b0, OFF_CTRL, ZERO8);
        chk("read_strobe", 8'h08, q);
        ac(1'b0, OFF_DATA, ZERO8);
        chk("read_data", d, q);
        eac_cpu_model_inst.write_byte(9'h000, ~d, 1'b0, 6);
        ac(1'b0, OFF_CTRL, ZERO8);
        chk("mwe_timeout", ZERO8, q);
        seed = xs(seed);
        eac_cpu_model_inst.write_byte(9'h0aa, seed[7:0], 1'b0, 0);
        @(posedge clk_in);
        nrst_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        nrst_in <= 1'b1;
        #1;
        ac(1'b0, OFF_CTRL, ZERO8);
        chk("reset_busy", 8'h02, q);
        eac_cpu_model_inst.wait_ready(q);
        ac(1'b1, OFF_ADDR_L, 8'haa);
        ac(1'b1, OFF_ADDR_H, ZERO8);
        ac(1'b1, OFF_CTRL, 8'h01);
        ac(1'b0, OFF_DATA, ZERO8);
        chk("reset_data", seed[7:0], q);
        end_sim();
    end
endmodule // tb_top

`default_nettype wire
